// ==== lpb_pkg.sv ====
// Package with constants and types of the LED PWM channel bank
package lpb_pkg;

   // Channel count and PWM resolution
   localparam int CHANNELS = 36;
   localparam int PWM_STEPS = 256;

   // Register offsets
   localparam logic [7:0] REG_POWER = 8'h00;
   localparam logic [7:0] REG_DUTY_BASE = 8'h01;
   localparam logic [7:0] REG_COMMIT = 8'h25;
   localparam logic [7:0] REG_CTRL_BASE = 8'h26;
   localparam logic [7:0] REG_GLOBAL = 8'h4a;
   localparam logic [7:0] REG_RATE = 8'h4b;
   localparam logic [7:0] REG_SOFT_RESET = 8'h4f;

   // Trigger value for commit and soft reset
   localparam logic [7:0] TRIGGER_VALUE = 8'h00;

   // Field positions
   localparam int POWER_BIT = 0;
   localparam int GLOBAL_OFF_BIT = 0;
   localparam int RATE_BIT = 0;
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_SCALE_LSB = 1;
   localparam int CTRL_WIDTH = 3;

   // Reset values
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 3'h0;
   localparam logic BIT_RESET = 1'b0;

   // Serial bus address: fixed upper bits, strap supplies the low two
   localparam logic [4:0] BUS_ADDR_HIGH = 5'h0f;

   // Clock and PWM rates
   localparam int CLK_HZ = 10_000_000;
   localparam int RATE_LO_HZ = 3000;
   localparam int RATE_HI_HZ = 22000;
   localparam int DIV_LO = (CLK_HZ + RATE_LO_HZ * 128) / (RATE_LO_HZ * PWM_STEPS);
   localparam int DIV_HI = (CLK_HZ + RATE_HI_HZ * 128) / (RATE_HI_HZ * PWM_STEPS);
   localparam logic [7:0] DIV_LO_CNT = 8'(DIV_LO - 1);
   localparam logic [7:0] DIV_HI_CNT = 8'(DIV_HI - 1);

   // One register write taken from the serial link
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } lpb_wr_t;

   // Serial receive states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DEV = 5'b00010,
      ST_REG = 5'b00100,
      ST_DATA = 5'b01000,
      ST_ACK = 5'b10000
   } lpb_state_t;

endpackage : lpb_pkg

// ==== lpb_pwm_channel.sv ====
// One PWM output channel compared against the shared step counter
`timescale 1ns/1ps
`default_nettype none
module lpb_pwm_channel (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Shared step counter and channel setting
   input wire logic [7:0] step,
   input wire logic [7:0] duty,
   input wire logic run,
   // Output
   output logic led_on
);
   import lpb_pkg::*;

   // On for duty of every 256 steps; zero duty stays dark
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         led_on <= 1'b0;
      end else begin
         led_on <= run && (step < duty); // RULE_04 RULE_05
      end
   end

endmodule : lpb_pwm_channel
`default_nettype wire

// ==== lpb_channel_bank.sv ====
// Top of the LED PWM channel bank: serial write port, registers and PWM engine
// What this block does
// RULE_01 - Power bit: 0 shutdown, 1 normal
// RULE_02 - Thirty-six 8-bit duty registers, reset zero
// RULE_03 - Duty addresses ascend with channel number
// RULE_04 - Output on for duty/256 per period
// RULE_05 - Step equals binary duty value
// RULE_06 - Duty and control writes land in shadows
// RULE_07 - Commit write of zero loads active copies
// RULE_08 - Control bit 0 enables channel, reset zero
// RULE_09 - Control bits 2:1 choose current scale
// RULE_10 - Global bit forces all outputs off
// RULE_11 - Rate bit: 0 3 kHz, 1 22 kHz (divider of 2 gives about 19.5 kHz here)
// RULE_12 - Soft reset write restores all defaults
// RULE_13 - Power-up leaves every output dark
// RULE_14 - Host may repeat duty and commit writes
// RULE_15 - Write-only bus, strap sets address low bits
// RULE_16 - Pointer advances after each acknowledged data byte
// RULE_17 - Global 1 or shutdown darkens all outputs
// RULE_18 - Commit updates all channels on one edge
`timescale 1ns/1ps
`default_nettype none
module lpb_channel_bank #(
   parameter int CHANNELS = lpb_pkg::CHANNELS
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Straps and power-down pin
   input wire logic [1:0] addr_strap,
   input wire logic hardware_power_down_pin_n,
   // LED outputs
   output logic [CHANNELS-1:0] led_outputs,
   output logic [2*CHANNELS-1:0] current_scale
);
   import lpb_pkg::*;

   // Serial sampling and receive state
   logic scl_q;
   logic sda_q;
   logic [1:0] strap_q;
   logic strap_done_q;
   lpb_state_t state_q;
   lpb_state_t after_ack_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] pointer_q;
   lpb_wr_t wr_q;
   logic wr_valid_q;

   // Register bank
   logic power_q;
   logic global_off_q;
   logic pwm_rate_bit_q;
   logic [7:0] duty_shadow_q [CHANNELS];
   logic [7:0] duty_active_q [CHANNELS];
   logic [CTRL_WIDTH-1:0] ctrl_shadow_q [CHANNELS];
   logic [CTRL_WIDTH-1:0] ctrl_active_q [CHANNELS];

   // PWM timebase
   logic [7:0] prescale_q;
   logic [7:0] step_q;
   logic run_all;

   // Bus conditions seen on the sampled pins
   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;
   logic dev_match;
   logic commit_hit;
   logic soft_reset_hit;

   assign start_seen = scl_in && scl_q && sda_q && !sda_in;
   assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
   assign scl_rise = scl_in && !scl_q;
   assign scl_fall = !scl_in && scl_q;
   assign dev_match = (shift_q[7:1] == {BUS_ADDR_HIGH, strap_q}) && !shift_q[0]; // RULE_15
   // Commit and soft reset fire only on an exact zero data byte
   // Any other value at these offsets is acknowledged and dropped
   assign commit_hit = wr_valid_q && (wr_q.addr == REG_COMMIT)
                       && (wr_q.data == TRIGGER_VALUE); // RULE_07
   assign soft_reset_hit = wr_valid_q && (wr_q.addr == REG_SOFT_RESET)
                           && (wr_q.data == TRIGGER_VALUE); // RULE_12

   // Previous pin levels for edge and condition detection
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Address strap caught once, just after reset release
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_q <= 2'h0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q <= addr_strap; // RULE_15
         strap_done_q <= 1'b1;
      end
   end

   // Serial receive machine: address, register pointer, then data bytes
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         after_ack_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         pointer_q <= 8'h00;
         sda_oe_n <= 1'b1;
      end else if (!hardware_power_down_pin_n) begin
         // Pin low holds the port idle and released
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (start_seen) begin
         state_q <= ST_DEV;
         bit_cnt_q <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         sda_oe_n <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               sda_oe_n <= 1'b1;
            end
            ST_DEV, ST_REG, ST_DATA: begin
               if (scl_rise && bit_cnt_q != 4'h8) begin
                  shift_q <= {shift_q[6:0], sda_in};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == 4'h8) begin
                  bit_cnt_q <= 4'h0;
                  if (state_q == ST_DEV) begin
                     if (dev_match) begin
                        sda_oe_n <= 1'b0;
                        state_q <= ST_ACK;
                        after_ack_q <= ST_REG;
                     end else begin
                        state_q <= ST_IDLE; // RULE_15
                     end
                  end else if (state_q == ST_REG) begin
                     pointer_q <= shift_q;
                     sda_oe_n <= 1'b0;
                     state_q <= ST_ACK;
                     after_ack_q <= ST_DATA;
                  end else begin
                     pointer_q <= pointer_q + 8'h01; // RULE_16
                     sda_oe_n <= 1'b0;
                     state_q <= ST_ACK;
                     after_ack_q <= ST_DATA;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  sda_oe_n <= 1'b1;
                  state_q <= after_ack_q;
               end
            end
         endcase
      end
   end

   // Data line is only ever pulled low
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // One write pulse per received data byte, at its acknowledge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         wr_valid_q <= 1'b0;
      end else begin
         wr_valid_q <= (state_q == ST_DATA) && scl_fall && (bit_cnt_q == 4'h8)
                       && hardware_power_down_pin_n && !start_seen && !stop_seen;
         wr_q.addr <= pointer_q;
         wr_q.data <= shift_q;
      end
   end

   // Plain control registers, taking effect at once
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_q <= BIT_RESET; // RULE_13
         global_off_q <= BIT_RESET;
         pwm_rate_bit_q <= BIT_RESET;
      end else if (soft_reset_hit) begin
         power_q <= BIT_RESET; // RULE_12
         global_off_q <= BIT_RESET;
         pwm_rate_bit_q <= BIT_RESET;
      end else if (wr_valid_q) begin
         if (wr_q.addr == REG_POWER) begin
            power_q <= wr_q.data[POWER_BIT]; // RULE_01
         end
         if (wr_q.addr == REG_GLOBAL) begin
            global_off_q <= wr_q.data[GLOBAL_OFF_BIT]; // RULE_10
         end
         if (wr_q.addr == REG_RATE) begin
            pwm_rate_bit_q <= wr_q.data[RATE_BIT]; // RULE_11
         end
      end
   end

   // Shadow copies take duty and control writes
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_shadow_q[i] <= DUTY_RESET; // RULE_02
            ctrl_shadow_q[i] <= CTRL_RESET; // RULE_08
         end
      end else if (soft_reset_hit) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_shadow_q[i] <= DUTY_RESET; // RULE_12
            ctrl_shadow_q[i] <= CTRL_RESET;
         end
      end else if (wr_valid_q) begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (wr_q.addr == REG_DUTY_BASE + 8'(i)) begin
               duty_shadow_q[i] <= wr_q.data; // RULE_03 RULE_06
            end
            if (wr_q.addr == REG_CTRL_BASE + 8'(i)) begin
               ctrl_shadow_q[i] <= wr_q.data[CTRL_WIDTH-1:0]; // RULE_06 RULE_09
            end
         end
      end
   end

   // Active copies load together from the shadows on commit
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_active_q[i] <= DUTY_RESET; // RULE_13
            ctrl_active_q[i] <= CTRL_RESET;
         end
      end else if (soft_reset_hit) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_active_q[i] <= DUTY_RESET; // RULE_12
            ctrl_active_q[i] <= CTRL_RESET;
         end
      end else if (commit_hit) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_active_q[i] <= duty_shadow_q[i]; // RULE_07 RULE_18
            ctrl_active_q[i] <= ctrl_shadow_q[i];
         end
      end
   end

   // Prescaler and 256-step counter shared by every channel
   // A rate change takes hold at the next reload, so one step may run long
   // Every channel shares the step count, so all periods stay aligned
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_q <= 8'h00;
         step_q <= 8'h00;
      end else if (prescale_q == 8'h00) begin
         prescale_q <= pwm_rate_bit_q ? DIV_HI_CNT : DIV_LO_CNT; // RULE_11
         step_q <= step_q + 8'h01; // RULE_04
      end else begin
         prescale_q <= prescale_q - 8'h01;
      end
   end

   // Outputs run only when powered, globally allowed and pin high
   assign run_all = power_q && !global_off_q && hardware_power_down_pin_n; // RULE_17

   // Per-channel comparators
   for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
      lpb_pwm_channel u_chan (
         .ref_clk(ref_clk),
         .reset_n(reset_n),
         .step(step_q),
         .duty(duty_active_q[g]),
         .run(run_all && ctrl_active_q[g][CTRL_ON_BIT]), // RULE_08 RULE_10
         .led_on(led_outputs[g])
      );
   end

   // Registered current scale per channel
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         current_scale <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            current_scale[2*i +: 2] <= ctrl_active_q[i][CTRL_SCALE_LSB +: 2]; // RULE_09
         end
      end
   end

endmodule : lpb_channel_bank
`default_nettype wire

// ==== lpb_bank_sva.sv ====
// Assertion checker for the LED PWM channel bank ports
`timescale 1ns/1ps
`default_nettype none
module lpb_bank_sva #(
   parameter int CHANNELS = 36
) (
   // Clock, reset and serial pins
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // Straps, pin and outputs
   input wire logic [1:0] addr_strap,
   input wire logic hardware_power_down_pin_n,
   input wire logic [CHANNELS-1:0] led_outputs,
   input wire logic [2*CHANNELS-1:0] current_scale
);
   // All checks run on the core clock
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   reset_dark_a: assert property (
      $rose(reset_n) |-> led_outputs == '0 && current_scale == '0) else $error("lit at reset");
   pin_dark_a: assert property (
      !hardware_power_down_pin_n [*2] |-> led_outputs == '0) else $error("lit with pin low");
   pin_idle_a: assert property (
      !hardware_power_down_pin_n [*2] |-> sda_oe_n) else $error("ack with pin low");
   sda_low_a: assert property (
      sda_out == 1'b0) else $error("data drive high");
   ack_edge_a: assert property (
      $fell(sda_oe_n) |-> !scl_in) else $error("ack starts in clock high");
   ack_hold_a: assert property (
      !sda_oe_n && scl_in |=> !sda_oe_n) else $error("ack dropped early");
   scale_edge_a: assert property (
      $changed(current_scale) |-> !scl_in) else $error("scale moved mid bit");
   scale_once_a: assert property (
      $changed(current_scale) |=> $stable(current_scale) [*8]) else $error("scale split");
endmodule : lpb_bank_sva
bind lpb_channel_bank lpb_bank_sva #(.CHANNELS(CHANNELS)) u_sva (.ref_clk(ref_clk),
   .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .addr_strap(addr_strap),
   .hardware_power_down_pin_n(hardware_power_down_pin_n), .led_outputs(led_outputs),
   .current_scale(current_scale));
`default_nettype wire

// ==== lpb_host_model.sv ====
// Behavioural host that writes the bank over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module lpb_host_model (
   // Clock and bus sense
   input wire logic ref_clk,
   input wire logic sda_in,
   // Bus drive, high releases data to the pull-up
   output logic scl,
   output logic sda_rel
);
   logic ack_ok;
   // Idle bus is released high
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
      ack_ok = 1'b0;
   end
   // Wait n core cycles, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   // Data falls while the clock is high
   task automatic start;
      sda_rel = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(2);
   endtask : start
   // Byte MSB first, then a ninth pulse for the answer
   task automatic put(input logic [7:0] b);
      for (int i = 8; i >= 0; i--) begin
         sda_rel = (i == 0) ? 1'b1 : b[i-1];
         tick(4);
         scl = 1'b1;
         tick(2);
         if (i == 0) ack_ok = (sda_in === 1'b0);
         tick(2);
         scl = 1'b0;
         tick(2);
      end
   endtask : put
   // Data rises while the clock is high
   task automatic stop;
      sda_rel = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_rel = 1'b1;
      tick(6);
   endtask : stop
   // One register write in its own transfer
   task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
      start;
      put({dev, 1'b0});
      put(p);
      put(d);
      stop;
   endtask : wr
endmodule : lpb_host_model
`default_nettype wire

// ==== lpb_channel_bank_tb.sv ====
// Self-checking testbench for the LED PWM channel bank
`timescale 1ns/1ps
`default_nettype none
module lpb_channel_bank_tb;
   import lpb_pkg::*;
   localparam logic [6:0] DEV = {BUS_ADDR_HIGH, 2'b10};
   localparam logic [6:0] DEV2 = {BUS_ADDR_HIGH, 2'b01};
   localparam int PL = DIV_LO * PWM_STEPS;
   localparam int PH = DIV_HI * PWM_STEPS;
   logic ref_clk, reset_n, pin_n, scl, sda_rel, sda_out, sda_oe_n;
   logic [CHANNELS-1:0] leds;
   logic [2*CHANNELS-1:0] scale;
   logic [1:0] strap;
   int err_total, checked;
   // Open-drain data line with pull-up
   wire logic sda = sda_rel & (sda_oe_n | sda_out);
   lpb_channel_bank u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(strap),
      .hardware_power_down_pin_n(pin_n), .led_outputs(leds), .current_scale(scale));
   lpb_host_model u_host (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_rel(sda_rel));
   // Compare and count
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %0h want %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // Acknowledged single write
   task automatic w(input logic [7:0] p, input logic [7:0] d);
      u_host.wr(DEV, p, d);
      chk(72'(u_host.ack_ok), 72'(1));
   endtask : w
   // Lit cycles of one channel over n cycles after settling
   task automatic lit(input int ch, input int n, input int exp);
      int c;
      c = 0;
      repeat (4) @(posedge ref_clk);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         // An unknown level overfills the count so it cannot pass as dark
         c += (leds[ch] === 1'b1) ? 1 : ((leds[ch] === 1'b0) ? 0 : n + 1);
      end
      chk(72'(c), 72'(exp));
   endtask : lit
   // Dark after power-up
   task automatic t_reset;
      chk(scale, '0);
      chk(72'(leds), '0);
      lit(0, PL, 0);
   endtask : t_reset
   // Shadowed settings, commit, duty steps and rate
   task automatic t_duty;
      w(8'h00, 8'h01);
      u_host.start;
      u_host.put({DEV, 1'b0});
      u_host.put(8'h01);
      u_host.put(8'h80);
      u_host.put(8'h04);
      u_host.stop;
      chk(72'(u_host.ack_ok), 72'(1));
      w(8'h24, 8'hff);
      w(8'h26, 8'h03);
      w(8'h27, 8'h05);
      w(8'h49, 8'h07);
      lit(0, PL, 0);
      chk(scale, '0);
      w(8'h25, 8'h00);
      chk(scale, {2'b11, 66'h0, 2'b10, 2'b01});
      lit(0, PL, 128 * DIV_LO);
      lit(1, PL, 4 * DIV_LO);
      lit(35, PL, 255 * DIV_LO);
      w(8'h4b, 8'h01);
      lit(0, PH, 128 * DIV_HI);
      w(8'h01, 8'h10);
      w(8'h25, 8'h01);
      lit(0, PH, 128 * DIV_HI);
      w(8'h25, 8'h00);
      lit(0, PH, 16 * DIV_HI);
   endtask : t_duty
   // Global, power bit and power-down pin darken outputs
   task automatic t_gate;
      w(8'h4a, 8'h01);
      lit(0, PH, 0);
      w(8'h4a, 8'h00);
      w(8'h00, 8'h00);
      lit(0, PH, 0);
      w(8'h00, 8'h01);
      pin_n = 1'b0;
      lit(0, PH, 0);
      pin_n = 1'b1;
      lit(0, PH, 16 * DIV_HI);
   endtask : t_gate
   // Wrong address, read bit and unmapped offset
   task automatic t_addr;
      u_host.wr(DEV ^ 7'h01, 8'h01, 8'h00);
      chk(72'(u_host.ack_ok), 72'(0));
      u_host.start;
      u_host.put({DEV, 1'b1});
      chk(72'(u_host.ack_ok), 72'(0));
      u_host.stop;
      w(8'h4c, 8'h55);
      lit(0, PH, 16 * DIV_HI);
   endtask : t_addr
   // Soft reset clears actives and shadows
   task automatic t_soft;
      w(8'h4f, 8'h01);
      lit(0, PH, 16 * DIV_HI);
      w(8'h4f, 8'h00);
      chk(scale, '0);
      w(8'h00, 8'h01);
      w(8'h25, 8'h00);
      lit(0, PL, 0);
   endtask : t_soft
   // Second reset with a new strap moves the bus address
   task automatic t_strap;
      strap = 2'b01;
      reset_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(72'(leds), '0);
      chk(scale, '0);
      u_host.wr(DEV, 8'h00, 8'h01);
      chk(72'(u_host.ack_ok), 72'(0));
      u_host.wr(DEV2, 8'h00, 8'h01);
      chk(72'(u_host.ack_ok), 72'(1));
   endtask : t_strap
   // Core clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Hang guard
   initial begin
      repeat (95000) @(posedge ref_clk);
      err_total++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      reset_n = 1'b0;
      pin_n = 1'b1;
      strap = 2'b10;
      err_total = 0;
      checked = 0;
      repeat (3) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      t_reset;
      t_duty;
      t_gate;
      t_addr;
      t_soft;
      t_strap;
      tally_and_finish;
   end
endmodule : lpb_channel_bank_tb
`default_nettype wire
